//--- cocio_pkg.sv
package cocio_pkg;

  // Sizes of the status flags, input paths and output section
  localparam int NUM_DIV = 4;
  localparam int NUM_DRV = 4;
  localparam int NUM_FLAG = 4;
  localparam int NUM_IN = 2;
  localparam int SEL_W = 2;
  localparam int DLY_W = 16;
  localparam int HALF_W = 8;
  localparam int DIS_W = 2;

  // Status flag positions
  localparam int FLAG_LOS = 0;
  localparam int FLAG_OOF = 1;
  localparam int FLAG_LOL = 2;
  localparam int FLAG_HOLD = 3;

  // Delay line: step and one-sided span
  localparam int DLY_STEP_FS = 280;
  localparam int DLY_SPAN_PS = 9140;
  localparam int DLY_MAX_I = (DLY_SPAN_PS * 1000) / DLY_STEP_FS;
  localparam logic signed [DLY_W-1:0] DLY_MAX = DLY_W'(DLY_MAX_I);
  localparam logic signed [DLY_W-1:0] DLY_MIN = DLY_W'(-DLY_MAX_I);

  // Disabled driver states
  localparam logic [DIS_W-1:0] DIS_LOW = 2'h0;
  localparam logic [DIS_W-1:0] DIS_HIGH = 2'h1;
  localparam logic [DIS_W-1:0] DIS_HIZ = 2'h2;

  // Nonvolatile store
  localparam logic [1:0] NVM_MAX_WR = 2'h2;

  // Page addressing
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] PAGE_SEL_OFS = 8'h01;

  typedef enum logic {ST_LOAD, ST_RUN} cocio_state_t;

endpackage

//--- cocio_drv.sv
`timescale 1ns/1ps
module cocio_drv
  import cocio_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Source clock and controls
  input wire logic src_clk,
  input wire logic en,
  input wire logic pdn,
  input wire logic sync_dis,
  input wire logic se_mode,
  input wire logic pol_p,
  input wire logic pol_n,
  input wire logic [DIS_W-1:0] dis_state,
  // Pin pair
  output logic pin_p,
  output logic pin_n,
  output logic oe_p,
  output logic oe_n
);

  logic running;

  // Start only while the source is low so the first pulse is whole
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      running <= 1'b0;
    end else if (!en && (!sync_dis || !src_clk)) begin
      running <= 1'b0;
    end else if (en && !src_clk) begin
      running <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_p <= 1'b0;
      pin_n <= 1'b0;
      oe_p <= 1'b0;
      oe_n <= 1'b0;
    end else if (pdn) begin
      pin_p <= 1'b0;
      pin_n <= 1'b0;
      oe_p <= 1'b0;
      oe_n <= 1'b0;
    end else if (running) begin
      pin_p <= se_mode ? (src_clk ^ pol_p) : src_clk;
      pin_n <= se_mode ? (src_clk ^ pol_n) : ~src_clk;
      oe_p <= 1'b1;
      oe_n <= 1'b1;
    end else begin
      pin_p <= (dis_state == DIS_HIGH);
      pin_n <= (dis_state == DIS_HIGH);
      oe_p <= (dis_state != DIS_HIZ);
      oe_n <= (dis_state != DIS_HIZ);
    end
  end

  a_sync_no_runt: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($fell(running) && $past(sync_dis)) |-> !$past(src_clk))
    else $error("synchronous disable cut a high phase");

  a_immed_stop: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!en && !sync_dis) |=> !running ##1
      ($past(pdn) || (oe_p == ($past(dis_state) != DIS_HIZ) &&
        pin_p == ($past(dis_state) == DIS_HIGH))))
    else $error("immediate disable did not stop the driver");

  a_pdn_hiz: assert property (@(posedge ref_clk) disable iff (!nrst)
    pdn |=> (!oe_p && !oe_n))
    else $error("powered down driver still drives");

endmodule

//--- cocio_top.sv
// What this block does
// - Interrupt pin asserts when any loss, range, lock or holdover flag changes.
// - Each status flag has a mask that blocks it from the interrupt pin.
// - Interrupt pin releases when host clears the causing sticky bit or masks it.
// - Each flag has a live bit and a sticky bit held until cleared.
// - Crosspoint lets each driver take any fractional divider as its clock.
// - Crosspoint selection loads from nonvolatile store at power-up.
// - Single-ended driver clocks both pins, in phase by default.
// - Each single-ended pin has its own polarity control.
// - Output gate pin high disables all drivers; low enables them.
// - Each driver can be disabled by its own control bit.
// - Disabled driver state is low, high or high impedance.
// - Synchronous disable waits for the current clock period to finish.
// - Without synchronous disable, the driver stops at once.
// - Four dividers, each with a delay path, phase aligned by default.
// - Delay setting steps about 0.28 ps over plus or minus 9.14 ns.
// - Delay settings revert to defaults on power-up, hard reset, reset pin.
// - Delay defaults come from the nonvolatile store after any reset.
// - Output dividers are forced to a known state at init and resets.
// - Sync request realigns all output dividers without a device reset.
// - Unused input paths and drivers can each be powered down.
// - Defaults load from nonvolatile store before normal operation.
// - Store accepts two writes; only the newest image is readable.
// - Host access is I2C or SPI, chosen by the interface select pin.
// - SPI runs with separate data lines or one shared data line.
// - Page byte plus offset; page starts at zero, changed at offset 0x01.
`timescale 1ns/1ps
module cocio_top
  import cocio_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Status monitors and interrupt
  input wire logic [NUM_FLAG-1:0] status_raw,
  input wire logic [NUM_FLAG-1:0] flag_mask,
  input wire logic [NUM_FLAG-1:0] sticky_clr,
  output logic [NUM_FLAG-1:0] live_flags,
  output logic [NUM_FLAG-1:0] sticky_flags,
  output logic interrupt_request_pin,
  // Reset and realign requests
  input wire logic hard_reset,
  input wire logic sync_req,
  // Host configuration
  input wire logic cfg_we,
  input wire logic [NUM_DRV*SEL_W-1:0] cfg_xsel,
  input wire logic [NUM_DIV*DLY_W-1:0] cfg_dly,
  input wire logic [NUM_DIV*HALF_W-1:0] cfg_half,
  // Driver controls
  input wire logic out_gate_pin,
  input wire logic [NUM_DRV-1:0] drv_dis,
  input wire logic [NUM_DRV-1:0] drv_pdn,
  input wire logic [NUM_DRV-1:0] drv_se,
  input wire logic [NUM_DRV-1:0] drv_sync_dis,
  input wire logic [NUM_DRV-1:0] drv_pol_p,
  input wire logic [NUM_DRV-1:0] drv_pol_n,
  input wire logic [NUM_DRV*DIS_W-1:0] drv_dis_state,
  // Input paths
  input wire logic [NUM_IN-1:0] in_pdn,
  output logic [NUM_IN-1:0] in_path_en,
  // Nonvolatile store
  input wire logic [NUM_DRV*SEL_W-1:0] nvm_xsel,
  input wire logic [NUM_DIV*DLY_W-1:0] nvm_dly,
  input wire logic [NUM_DIV*HALF_W-1:0] nvm_half,
  input wire logic [1:0] nvm_used,
  input wire logic nvm_burn_req,
  output logic nvm_prog,
  output logic nvm_wr_slot,
  output logic nvm_rd_slot,
  output logic nvm_burn_err,
  // Serial interface
  input wire logic iface_sel_pin,
  input wire logic spi_3wire,
  input wire logic reg_we,
  input wire logic [7:0] reg_ofs,
  input wire logic [7:0] reg_data,
  output logic spi_mode,
  output logic spi_3wire_act,
  output logic [7:0] page,
  // Output pins and delay codes
  output logic [NUM_DRV-1:0] output_pin_pair_p,
  output logic [NUM_DRV-1:0] output_pin_pair_n,
  output logic [NUM_DRV-1:0] output_pin_pair_oe_p,
  output logic [NUM_DRV-1:0] output_pin_pair_oe_n,
  output logic [NUM_DIV*DLY_W-1:0] path_delay_setting,
  output logic dev_ready
);

  cocio_state_t state;
  logic [NUM_FLAG-1:0] stat_s1;
  logic [NUM_FLAG-1:0] stat_s2;
  logic [NUM_FLAG-1:0] live_d;
  logic [NUM_FLAG-1:0] chg;
  logic gate_s1;
  logic gate_s2;
  logic isel_s1;
  logic isel_s2;
  logic realign;
  logic loading;
  logic [1:0] nvm_cnt;
  logic [SEL_W-1:0] act_xsel [NUM_DRV];
  logic [HALF_W-1:0] act_half [NUM_DIV];
  logic [HALF_W-1:0] div_cnt [NUM_DIV];
  logic [NUM_DIV-1:0] div_clk;
  logic [NUM_DRV-1:0] drv_en_v;

  function automatic logic signed [DLY_W-1:0] clamp_dly(
    input logic signed [DLY_W-1:0] v
  );
    if (v > DLY_MAX) begin
      return DLY_MAX;
    end else if (v < DLY_MIN) begin
      return DLY_MIN;
    end
    return v;
  endfunction

  // Load phase after power-up, reset pin or hard reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_LOAD;
    end else if (hard_reset) begin
      state <= ST_LOAD;
    end else begin
      case (state)
        ST_LOAD: state <= ST_RUN;
        ST_RUN: state <= ST_RUN;
        default: state <= ST_LOAD;
      endcase
    end
  end

  assign loading = (state == ST_LOAD);
  assign realign = loading | sync_req;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dev_ready <= 1'b0;
    end else begin
      dev_ready <= !loading && !hard_reset;
    end
  end

  // Monitor flags come from other clock domains
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stat_s1 <= '0;
      stat_s2 <= '0;
      live_d <= '0;
    end else begin
      stat_s1 <= status_raw;
      stat_s2 <= stat_s1;
      live_d <= stat_s2;
    end
  end

  assign chg = stat_s2 ^ live_d;

  // A change in the clearing cycle still sets the sticky bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      live_flags <= '0;
      sticky_flags <= '0;
    end else begin
      live_flags <= stat_s2;
      sticky_flags <= (sticky_flags & ~sticky_clr) | chg;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_request_pin <= 1'b0;
    end else begin
      interrupt_request_pin <= |(sticky_flags & ~flag_mask);
    end
  end

  // Output gate and interface select pins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gate_s1 <= 1'b1;
      gate_s2 <= 1'b1;
      isel_s1 <= 1'b1;
      isel_s2 <= 1'b1;
    end else begin
      gate_s1 <= out_gate_pin;
      gate_s2 <= gate_s1;
      isel_s1 <= iface_sel_pin;
      isel_s2 <= isel_s1;
    end
  end

  // Select pin high means I2C
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      spi_mode <= 1'b0;
      spi_3wire_act <= 1'b0;
    end else begin
      spi_mode <= !isel_s2;
      spi_3wire_act <= !isel_s2 && spi_3wire;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      page <= PAGE_RST;
    end else if (hard_reset) begin
      page <= PAGE_RST;
    end else if (reg_we && reg_ofs == PAGE_SEL_OFS) begin
      page <= reg_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      in_path_en <= '0;
    end else begin
      in_path_en <= ~in_pdn;
    end
  end

  // Store programming: the count is taken from the store at each load
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nvm_cnt <= '0;
      nvm_prog <= 1'b0;
      nvm_wr_slot <= 1'b0;
      nvm_burn_err <= 1'b0;
    end else if (loading) begin
      nvm_cnt <= nvm_used;
      nvm_prog <= 1'b0;
      nvm_burn_err <= 1'b0;
    end else if (nvm_burn_req && nvm_cnt < NVM_MAX_WR) begin
      nvm_prog <= 1'b1;
      nvm_wr_slot <= nvm_cnt[0];
      nvm_cnt <= nvm_cnt + 2'h1;
    end else begin
      nvm_prog <= 1'b0;
      if (nvm_burn_req) begin
        nvm_burn_err <= 1'b1;
      end
    end
  end

  // Only the newest image is ever read back
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nvm_rd_slot <= 1'b0;
    end else begin
      nvm_rd_slot <= (nvm_cnt == NVM_MAX_WR);
    end
  end

  genvar gd;
  generate
    for (gd = 0; gd < NUM_DIV; gd++) begin : g_div
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          act_half[gd] <= '0;
          path_delay_setting[gd*DLY_W +: DLY_W] <= '0;
        end else if (loading) begin
          act_half[gd] <= nvm_half[gd*HALF_W +: HALF_W];
          path_delay_setting[gd*DLY_W +: DLY_W] <=
            clamp_dly(nvm_dly[gd*DLY_W +: DLY_W]);
        end else if (cfg_we) begin
          act_half[gd] <= cfg_half[gd*HALF_W +: HALF_W];
          path_delay_setting[gd*DLY_W +: DLY_W] <=
            clamp_dly(cfg_dly[gd*DLY_W +: DLY_W]);
        end
      end

      // Every divider restarts from the same phase
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          div_cnt[gd] <= '0;
          div_clk[gd] <= 1'b0;
        end else if (realign) begin
          div_cnt[gd] <= '0;
          div_clk[gd] <= 1'b0;
        // A shorter half period written mid-count must not wait for a wrap
        end else if (div_cnt[gd] >= act_half[gd]) begin
          div_cnt[gd] <= '0;
          div_clk[gd] <= ~div_clk[gd];
        end else begin
          div_cnt[gd] <= div_cnt[gd] + 8'h01;
        end
      end

      a_delay_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        cfg_we && !loading && !hard_reset |=>
          $signed(path_delay_setting[gd*DLY_W +: DLY_W]) <= DLY_MAX &&
          $signed(path_delay_setting[gd*DLY_W +: DLY_W]) >= DLY_MIN)
        else $error("delay setting outside span");
    end
  endgenerate

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DRV; gi++) begin : g_drv
      logic drv_en;

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          act_xsel[gi] <= '0;
        end else if (loading) begin
          act_xsel[gi] <= nvm_xsel[gi*SEL_W +: SEL_W];
        end else if (cfg_we) begin
          act_xsel[gi] <= cfg_xsel[gi*SEL_W +: SEL_W];
        end
      end

      // Gate pin is active high; per-driver bit applies on top
      assign drv_en = !gate_s2 && !drv_dis[gi] && !loading;
      assign drv_en_v[gi] = drv_en;

      cocio_drv u_drv (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .src_clk(div_clk[act_xsel[gi]]),
        .en(drv_en),
        .pdn(drv_pdn[gi]),
        .sync_dis(drv_sync_dis[gi]),
        .se_mode(drv_se[gi]),
        .pol_p(drv_pol_p[gi]),
        .pol_n(drv_pol_n[gi]),
        .dis_state(drv_dis_state[gi*DIS_W +: DIS_W]),
        .pin_p(output_pin_pair_p[gi]),
        .pin_n(output_pin_pair_n[gi]),
        .oe_p(output_pin_pair_oe_p[gi]),
        .oe_n(output_pin_pair_oe_n[gi])
      );
    end
  endgenerate

  sequence s_unmasked_change;
    (|(chg & ~flag_mask)) ##1 $stable(flag_mask);
  endsequence

  sequence s_pending_kept;
    (|(sticky_flags & ~flag_mask & ~sticky_clr)) ##1 $stable(flag_mask);
  endsequence

  a_irq_on_change: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_unmasked_change |=> interrupt_request_pin)
    else $error("unmasked flag change raised no interrupt");

  a_irq_masked: assert property (@(posedge ref_clk) disable iff (!nrst)
    (sticky_flags & ~flag_mask) == '0 |=> !interrupt_request_pin)
    else $error("masked flag drove the interrupt pin");

  a_irq_held: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_pending_kept |=> interrupt_request_pin)
    else $error("interrupt released while cause still pending");

  a_sticky_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    |chg |=> (sticky_flags & $past(chg)) == $past(chg))
    else $error("flag change lost from sticky bits");

  a_sync_align: assert property (@(posedge ref_clk) disable iff (!nrst)
    sync_req |=> (div_clk == '0) && (div_cnt[0] == '0) && (div_cnt[1] == '0))
    else $error("dividers not realigned after sync");

  a_nvm_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    loading && !hard_reset |=> act_xsel[0] == $past(nvm_xsel[SEL_W-1:0]) ##1
      (dev_ready || $past(hard_reset)))
    else $error("crosspoint default not loaded");

  a_nvm_limit: assert property (@(posedge ref_clk) disable iff (!nrst)
    nvm_burn_req && !loading && nvm_cnt == NVM_MAX_WR |=> !nvm_prog && nvm_burn_err)
    else $error("third store write was accepted");

  a_page_sel: assert property (@(posedge ref_clk) disable iff (!nrst)
    reg_we && reg_ofs == PAGE_SEL_OFS && !hard_reset |=> page == $past(reg_data))
    else $error("page select write not taken");

  a_gate_off: assert property (@(posedge ref_clk) disable iff (!nrst)
    gate_s2 |-> (drv_en_v == '0))
    else $error("driver enabled while gate pin high");

endmodule

//--- cocio_nvm_model.sv
`timescale 1ns/1ps
module cocio_nvm_model
  import cocio_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Burn strobe from the device
  input wire logic nvm_prog,
  // Read data of the newest image
  output logic [NUM_DRV*SEL_W-1:0] nvm_xsel,
  output logic [NUM_DIV*DLY_W-1:0] nvm_dly,
  output logic [NUM_DIV*HALF_W-1:0] nvm_half,
  output logic [1:0] nvm_used
);
  // Fuse contents survive any reset, so the count has no reset branch
  logic [1:0] n_burn = 2'h0;

  always @(posedge ref_clk) begin
    if (nrst && nvm_prog === 1'h1 && n_burn != NVM_MAX_WR) begin
      n_burn <= n_burn + 2'h1;
    end
  end

  // Each burn shows a new image and hides the one before it
  assign nvm_used = n_burn;
  assign nvm_dly = {NUM_DIV{{14'h0040, n_burn}}};
  assign nvm_xsel = 8'hE4;
  assign nvm_half = {NUM_DIV{8'h03}};
endmodule

//--- clock_output_control_and_interrupt_tb_top.sv
`timescale 1ns/1ps
module clock_output_control_and_interrupt_tb_top
  import cocio_pkg::*;
;
  typedef struct packed {
    logic [3:0] raw, mask, clr, live, sticky;
    logic irq;
  } cocio_row_t;

  logic ref_clk, nrst, hard_reset, sync_req, cfg_we, out_gate_pin, nvm_burn_req;
  logic [3:0] status_raw, flag_mask, sticky_clr, live_flags, sticky_flags;
  logic interrupt_request_pin, nvm_prog, nvm_wr_slot, nvm_rd_slot, nvm_burn_err;
  logic [7:0] cfg_xsel, drv_dis_state, reg_ofs, reg_data, page;
  logic [63:0] cfg_dly, nvm_dly, path_delay_setting;
  logic [31:0] cfg_half, nvm_half;
  logic [7:0] nvm_xsel;
  logic [3:0] drv_dis, drv_pdn, drv_se, drv_sync_dis, drv_pol_p, drv_pol_n;
  logic [1:0] in_pdn, in_path_en, nvm_used;
  logic iface_sel_pin, spi_3wire, reg_we, spi_mode, spi_3wire_act, dev_ready, pr, er;
  logic [3:0] output_pin_pair_p, output_pin_pair_n, output_pin_pair_oe_p, output_pin_pair_oe_n;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int cnt;
  cocio_row_t rows [10] = '{
    '{4'h1, 4'h0, 4'h0, 4'h1, 4'h1, 1'h1}, '{4'h1, 4'h0, 4'h1, 4'h1, 4'h0, 1'h0},
    '{4'h3, 4'h2, 4'h0, 4'h3, 4'h2, 1'h0}, '{4'h3, 4'h0, 4'h0, 4'h3, 4'h2, 1'h1},
    '{4'h3, 4'h0, 4'hF, 4'h3, 4'h0, 1'h0}, '{4'hC, 4'h0, 4'h0, 4'hC, 4'hF, 1'h1},
    '{4'hC, 4'h0, 4'hF, 4'hC, 4'h0, 1'h0}, '{4'h0, 4'hF, 4'h0, 4'h0, 4'hC, 1'h0},
    '{4'h0, 4'h0, 4'h0, 4'h0, 4'hC, 1'h1}, '{4'h0, 4'h0, 4'hF, 4'h0, 4'h0, 1'h0}};

  cocio_top i_dut (.ref_clk, .nrst, .status_raw, .flag_mask, .sticky_clr, .live_flags,
    .sticky_flags, .interrupt_request_pin, .hard_reset, .sync_req, .cfg_we, .cfg_xsel,
    .cfg_dly, .cfg_half, .out_gate_pin, .drv_dis, .drv_pdn, .drv_se, .drv_sync_dis,
    .drv_pol_p, .drv_pol_n, .drv_dis_state, .in_pdn, .in_path_en, .nvm_xsel, .nvm_dly,
    .nvm_half, .nvm_used, .nvm_burn_req, .nvm_prog, .nvm_wr_slot, .nvm_rd_slot,
    .nvm_burn_err, .iface_sel_pin, .spi_3wire, .reg_we, .reg_ofs, .reg_data, .spi_mode,
    .spi_3wire_act, .page, .output_pin_pair_p, .output_pin_pair_n, .output_pin_pair_oe_p,
    .output_pin_pair_oe_n, .path_delay_setting, .dev_ready);

  cocio_nvm_model i_nvm (.ref_clk, .nrst, .nvm_prog, .nvm_xsel, .nvm_dly, .nvm_half,
    .nvm_used);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk_v(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Counts come from sampling a running clock, so a small slack is allowed
  task automatic chk_n(input string nm, input int e, input int g, input int tol);
    checks++;
    if (g > e + tol || g < e - tol) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic burn();
    nvm_burn_req = 1'h1;
    cyc_n(1);
    nvm_burn_req = 1'h0;
    pr = 1'h0;
    repeat (3) begin
      if (nvm_prog === 1'h1) pr = 1'h1;
      cyc_n(1);
    end
    er = nvm_burn_err;
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    {status_raw, flag_mask, sticky_clr, drv_dis, drv_pdn, drv_se} = 24'h0;
    {hard_reset, sync_req, cfg_we, out_gate_pin, nvm_burn_req, reg_we, spi_3wire} = 7'h0;
    {drv_pol_p, drv_pol_n, in_pdn, reg_ofs, reg_data, cfg_dly} = 90'h0;
    // Driver 0 stops at once, the others wait for the period to end
    drv_sync_dis = 4'hE;
    cfg_xsel = 8'hE4;
    cfg_half = {4{8'h03}};
    drv_dis_state = {DIS_HIZ, DIS_HIGH, DIS_LOW, DIS_LOW};
    iface_sel_pin = 1'h1;
    nrst = 1'h0;
    cyc_n(2);
    chk_v("dev_ready", 0, dev_ready);
    nrst = 1'h1;
    cyc_n(1);
    chk_v("dev_ready", 0, dev_ready);
    cyc_n(1);
    chk_v("dev_ready", 1, dev_ready);
    chk_v("path_delay_setting", {4{16'h0100}}, path_delay_setting);
    chk_v("page", 8'h00, page);
    chk_v("in_path_en", 2'h3, in_path_en);
    $display("test reset done");
    foreach (rows[i]) begin
      {status_raw, flag_mask, sticky_clr} = {rows[i].raw, rows[i].mask, rows[i].clr};
      cyc_n(6);
      chk_v("live_flags", rows[i].live, live_flags);
      chk_v("sticky_flags", rows[i].sticky, sticky_flags);
      chk_v("interrupt_request_pin", rows[i].irq, interrupt_request_pin);
    end
    sticky_clr = 4'h0;
    $display("test status done");
    cfg_dly = {16'h7FFF, 16'h8000, 16'h0001, 16'hFFFF};
    cfg_we = 1'h1;
    reg_we = 1'h1;
    {reg_ofs, reg_data} = 16'h0105;
    cyc_n(1);
    {reg_ofs, reg_data} = 16'h0209;
    cfg_we = 1'h0;
    cyc_n(1);
    reg_we = 1'h0;
    chk_v("path_delay_setting", {16'h7F82, 16'h807E, 16'h0001, 16'hFFFF},
      path_delay_setting);
    chk_v("page", 8'h05, page);
    $display("test delay and page done");
    cfg_half = {8'h07, 8'h03, 8'h01, 8'h00};
    for (int k = 0; k < 4; k++) begin
      cfg_xsel[1:0] = 2'(k);
      cfg_we = 1'h1;
      cyc_n(1);
      cfg_we = 1'h0;
      cyc_n(20);
      cnt = 0;
      repeat (64) begin
        pr = output_pin_pair_p[0];
        cyc_n(1);
        if (output_pin_pair_p[0] !== pr) cnt++;
      end
      chk_n("driver 0 toggles", 64 >> k, cnt, 2);
    end
    $display("test crosspoint done");
    cfg_half = {4{8'h03}};
    cfg_xsel = 8'hE4;
    cfg_we = 1'h1;
    cyc_n(1);
    cfg_we = 1'h0;
    sync_req = 1'h1;
    cyc_n(1);
    sync_req = 1'h0;
    cyc_n(20);
    cnt = 0;
    repeat (16) begin
      cyc_n(1);
      if (output_pin_pair_p !== 4'h0 && output_pin_pair_p !== 4'hF) cnt++;
    end
    chk_n("misaligned samples", 0, cnt, 0);
    for (int m = 0; m < 4; m++) begin
      drv_se[0] = (m > 0);
      drv_pol_n[0] = (m == 2);
      drv_pol_p[0] = (m == 3);
      cyc_n(4);
      cnt = 0;
      repeat (16) begin
        cyc_n(1);
        if ((output_pin_pair_p[0] === output_pin_pair_n[0]) != (m == 1)) cnt++;
      end
      chk_n("pin pair phase", 0, cnt, 0);
    end
    {drv_se, drv_pol_p, drv_pol_n} = 12'h0;
    $display("test sync and polarity done");
    out_gate_pin = 1'h1;
    cyc_n(24);
    chk_v("oe_p", 4'h7, output_pin_pair_oe_p);
    chk_v("oe_n", 4'h7, output_pin_pair_oe_n);
    chk_v("pin_p", 4'h4, output_pin_pair_p & 4'h7);
    out_gate_pin = 1'h0;
    drv_dis = 4'h2;
    cyc_n(24);
    chk_v("oe_p", 4'hF, output_pin_pair_oe_p);
    cnt = 0;
    repeat (16) begin
      pr = output_pin_pair_p[0];
      cyc_n(1);
      if (output_pin_pair_p[0] !== pr) cnt++;
      if (output_pin_pair_p[1] !== 1'h0) cnt += 100;
    end
    chk_n("enabled toggles", 4, cnt, 1);
    drv_dis = 4'h0;
    drv_pdn = 4'h1;
    in_pdn = 2'h1;
    cyc_n(3);
    chk_v("oe_p", 4'hE, output_pin_pair_oe_p & output_pin_pair_oe_n);
    chk_v("in_path_en", 2'h2, in_path_en);
    {drv_pdn, in_pdn} = 6'h0;
    $display("test enables done");
    iface_sel_pin = 1'h0;
    spi_3wire = 1'h1;
    cyc_n(4);
    chk_v("spi_mode", 1, spi_mode);
    chk_v("spi_3wire_act", 1, spi_3wire_act);
    spi_3wire = 1'h0;
    iface_sel_pin = 1'h1;
    cyc_n(4);
    chk_v("spi_3wire_act", 0, spi_3wire_act);
    chk_v("spi_mode", 0, spi_mode);
    $display("test interface done");
    for (int i = 0; i < 3; i++) begin
      burn();
      chk_v("nvm_prog", i < 2, pr);
      chk_v("nvm_burn_err", i == 2, er);
      chk_v("nvm_wr_slot", i > 0, nvm_wr_slot);
      chk_v("nvm_rd_slot", i > 0, nvm_rd_slot);
    end
    hard_reset = 1'h1;
    cyc_n(1);
    hard_reset = 1'h0;
    cyc_n(2);
    chk_v("path_delay_setting", {4{16'h0102}}, path_delay_setting);
    chk_v("page", 8'h00, page);
    chk_v("nvm_burn_err", 0, nvm_burn_err);
    burn();
    chk_v("nvm_burn_err", 1, er);
    $display("test store done");
    stop_test();
  end
endmodule
